// ---- rtl/vid_slew_fault_sequencer.sv ----
// How it works
// [R01] Each slew tick during a transition moves the DAC target one 25 mV step.
// [R02] Falling transitions wait two extra slew ticks before stepping; rising ones do not.
// [R03] Overvoltage checks run only when the protect-select input is high.
// [R04] Forced-PWM mode uses the DAC-relative overvoltage comparator flag.
// [R05] Pulse-skipping mode uses the fixed-threshold overvoltage comparator flag.
// [R06] Overvoltage sets the fault latch and starts shutdown in the same cycle.
// [R07] Fault latch holds shutdown until shutdown input goes low or supply drops.
// [R08] Undervoltage flag sets the fault latch and starts shutdown.
// [R09] After a fault ramp reaches zero, low gate high and high gate low.
// [R10] Undervoltage is ignored during transitions and 24 slew ticks after the final code.
// [R11] Thermal flag sets the fault latch and starts the soft-shutdown ramp.
// [R12] A thermal fault clears through the shutdown input only once the sensor reports cooling.
// [R13] VID 0 is 1.550 V, each count lowers 25 mV, code 31 shuts down.
// [R14] Test mode disables all fault detection and overlap mode.
// [R15] Entering test mode clears a set fault latch.
// [R16] Test mode is requested by the outside party driving the high test level.
// [R17] Start-up, shutdown and code changes all slew in single steps.
// [R18] Regulator-good freezes during transitions, resumes 24 slew ticks after final code.
// [R19] Shutdown targets zero, ignoring new VID codes while the fault latch is set.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module vid_slew_fault_sequencer #(
   parameter logic [15:0] SLEW_DIV_DEFAULT = vid_slew_pkg::SLEW_DIV_RST
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Processor and board inputs
   input wire logic [4:0] vid_code_bits,
   input wire logic shutdown_n_input,
   input wire logic test_level_detect,
   input wire logic overvoltage_protect_select,
   input wire logic skip_forced_pwm,
   input wire logic supply_below_1v,
   input wire vid_slew_pkg::fault_flags_s fault_flags,
   input wire logic pwm_on_request,
   // Regulator outputs
   output logic [vid_slew_pkg::DAC_W-1:0] dac_target,
   output logic low_side_gate_drive,
   output logic high_side_gate_drive,
   output logic regulator_good_out,
   output logic overlap_mode_en,
   output logic fault_latched,
   output logic irq
);
   import vid_slew_pkg::*;

   slew_state_e state_ff;
   logic [DAC_W-1:0] dac_ff;
   logic [15:0] div_ff;
   logic [15:0] tick_cnt_ff;
   logic tick;
   logic [1:0] sync_cnt_ff;
   logic [4:0] blank_cnt_ff;
   logic fault_ff;
   logic thermal_cause_ff;
   logic test_d_ff;
   logic rgood_ff;
   logic [INT_W-1:0] int_stat_ff;
   logic [INT_W-1:0] int_mask_ff;
   logic [DAC_W-1:0] goal;
   logic [DAC_W-1:0] stepped;
   logic ov_hit;
   logic uv_hit;
   logic th_hit;
   logic fault_set;
   logic fault_clr;
   logic test_mode;
   logic settled;
   logic trans_done;
   logic rgood_rise;
   logic nxt_rgood;
   logic [INT_W-1:0] int_evt;

   assign test_mode = test_level_detect;

   // Slew clock derived from the timing divider; a zero divider acts as one.
   assign tick = (tick_cnt_ff == 16'h0000);
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         tick_cnt_ff <= 16'h0000;
      else if (tick)
         tick_cnt_ff <= (div_ff > 16'h0001) ? div_ff - 16'h0001 : 16'h0000;
      else
         tick_cnt_ff <= tick_cnt_ff - 16'h0001;
   end

   // [R13] VID decode
   // [R19] Shutdown goal zero
   always_comb
   begin
      if (fault_ff || fault_set || !shutdown_n_input || vid_code_bits == VID_SHUTDOWN)
         goal = DAC_ZERO;
      else
         goal = DAC_TOP_STEP - {1'b0, vid_code_bits};
   end

   // [R01] One step per tick
   assign stepped = (goal > dac_ff) ? dac_ff + 6'h01 : dac_ff - 6'h01;

   // [R03] Protect select gate
   // [R04] Forced PWM comparator
   // [R05] Pulse skip comparator
   // [R14] Test disables detection
   assign ov_hit = overvoltage_protect_select && !test_mode &&
                   (skip_forced_pwm ? fault_flags.ov_dac_rel : fault_flags.ov_fixed);
   // [R10] Undervoltage blanking
   // [R08] Undervoltage fault
   assign uv_hit = fault_flags.undervoltage && settled && shutdown_n_input && !test_mode &&
                   dac_ff != DAC_ZERO;
   // [R11] Thermal fault
   assign th_hit = fault_flags.thermal_hot && !test_mode;
   assign fault_set = ov_hit || uv_hit || th_hit;
   assign settled = (state_ff == ST_STEADY);

   // [R07] Latch clear conditions
   // [R12] Thermal needs cooling
   // [R15] Test entry clears
   assign fault_clr = supply_below_1v || (test_mode && !test_d_ff) ||
                      (!shutdown_n_input && (!thermal_cause_ff || fault_flags.thermal_cooled));

   // [R06] Immediate latch set
   // A new fault wins over a clear in the same cycle so no event is lost.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         fault_ff <= 1'b0;
         thermal_cause_ff <= 1'b0;
      end
      else if (fault_set)
      begin
         fault_ff <= 1'b1;
         thermal_cause_ff <= thermal_cause_ff || th_hit;
      end
      else if (fault_clr)
      begin
         fault_ff <= 1'b0;
         thermal_cause_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         test_d_ff <= 1'b0;
      else
         test_d_ff <= test_mode;
   end

   // [R17] Stepped sequencing
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_STEADY;
         dac_ff <= DAC_ZERO;
         sync_cnt_ff <= 2'h0;
         blank_cnt_ff <= 5'h00;
      end
      else
      begin
         unique case (state_ff)
            ST_STEADY, ST_BLANK:
            begin
               if (goal < dac_ff)
               begin
                  // [R02] Falling sync delay
                  state_ff <= ST_SYNC;
                  sync_cnt_ff <= FALL_SYNC_TICKS;
               end
               else if (goal > dac_ff)
                  state_ff <= ST_SLEW;
               else if (state_ff == ST_BLANK && tick)
               begin
                  // [R10] Blank countdown
                  if (blank_cnt_ff == BLANK_TICKS - 5'h01)
                     state_ff <= ST_STEADY;
                  else
                     blank_cnt_ff <= blank_cnt_ff + 5'h01;
               end
            end
            ST_SYNC:
            begin
               if (tick)
               begin
                  sync_cnt_ff <= sync_cnt_ff - 2'h1;
                  if (sync_cnt_ff == 2'h1)
                     state_ff <= ST_SLEW;
               end
            end
            ST_SLEW:
            begin
               if (goal == dac_ff)
               begin
                  state_ff <= ST_BLANK;
                  blank_cnt_ff <= 5'h00;
               end
               else if (tick)
               begin
                  // [R01] Single step
                  dac_ff <= stepped;
                  if (stepped == goal)
                  begin
                     state_ff <= ST_BLANK;
                     blank_cnt_ff <= 5'h00;
                  end
               end
            end
         endcase
      end
   end

   assign trans_done = (state_ff == ST_BLANK) && tick && (goal == dac_ff) &&
                       (blank_cnt_ff == BLANK_TICKS - 5'h01);

   // [R18] Regulator good freeze
   // A latched fault forces the output low even mid-transition.
   always_comb
   begin
      nxt_rgood = rgood_ff;
      if (fault_ff || !shutdown_n_input)
         nxt_rgood = 1'b0;
      else if (settled)
         nxt_rgood = !fault_flags.undervoltage && dac_ff != DAC_ZERO;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         rgood_ff <= 1'b0;
      else
         rgood_ff <= nxt_rgood;
   end
   assign rgood_rise = nxt_rgood && !rgood_ff;

   // [R09] Gates forced at zero
   // [R14] Overlap off in test
   always_comb
   begin
      if (dac_ff == DAC_ZERO && goal == DAC_ZERO)
      begin
         low_side_gate_drive = 1'b1;
         high_side_gate_drive = 1'b0;
      end
      else
      begin
         low_side_gate_drive = !pwm_on_request;
         high_side_gate_drive = pwm_on_request;
      end
   end

   assign overlap_mode_en = !test_mode;
   assign dac_target = dac_ff;
   assign fault_latched = fault_ff;
   assign regulator_good_out = rgood_ff;

   // Register bus: address and data are taken in either order, one at a time.
   logic aw_hold_ff;
   logic w_hold_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic wr_go;
   logic [31:0] rd_mux;
   logic rd_ok;

   assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
   assign s_axi_wready = !w_hold_ff && !bvalid_ff;
   assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= 4'h0;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= (awaddr_ff[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
      end
   end

   // Divider register steers the slew clock rate.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         div_ff <= SLEW_DIV_DEFAULT;
      else if (wr_go && awaddr_ff == REG_CTRL)
      begin
         if (wstrb_ff[0])
            div_ff[7:0] <= wdata_ff[7:0];
         if (wstrb_ff[1])
            div_ff[15:8] <= wdata_ff[15:8];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         int_mask_ff <= '0;
      else if (wr_go && awaddr_ff == REG_INT_MASK && wstrb_ff[0])
         int_mask_ff <= wdata_ff[INT_W-1:0];
   end

   // Sticky status: a new event wins over a write-one clear in the same cycle.
   assign int_evt = {rgood_rise, trans_done, fault_set && !fault_ff};
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         int_stat_ff <= '0;
      else if (wr_go && awaddr_ff == REG_INT_STAT && wstrb_ff[0])
         int_stat_ff <= (int_stat_ff & ~wdata_ff[INT_W-1:0]) | int_evt;
      else
         int_stat_ff <= int_stat_ff | int_evt;
   end
   assign irq = |(int_stat_ff & int_mask_ff);

   always_comb
   begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         REG_CTRL: rd_mux = {16'h0000, div_ff};
         REG_STATUS: rd_mux = {16'h0000, 2'h0, state_ff, rgood_ff, thermal_cause_ff,
                               fault_ff, test_mode, 2'h0, dac_ff};
         REG_INT_STAT: rd_mux = {29'h00000000, int_stat_ff};
         REG_INT_MASK: rd_mux = {29'h00000000, int_mask_ff};
         default:
         begin
            rd_mux = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_mux;
         rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
         rvalid_ff <= 1'b0;
   end
endmodule // vid_slew_fault_sequencer

// ---- rtl/vid_slew_pkg.sv ----
package vid_slew_pkg;
   // DAC target is held in 25 mV steps above 0 V.
   localparam int DAC_W = 6;
   localparam int LSB_MV = 25;
   localparam int TOP_MV = 1550;
   localparam logic [DAC_W-1:0] DAC_TOP_STEP = DAC_W'(TOP_MV / LSB_MV);
   localparam logic [DAC_W-1:0] DAC_ZERO = 6'h00;
   localparam logic [4:0] VID_SHUTDOWN = 5'h1f;
   // Slew clock period with a nominal timing resistor.
   localparam int CLK_PERIOD_NS = 10;
   localparam int SLEW_PERIOD_NS = 2000;
   localparam logic [15:0] SLEW_DIV_RST = 16'(SLEW_PERIOD_NS / CLK_PERIOD_NS);
   localparam logic [1:0] FALL_SYNC_TICKS = 2'h2;
   localparam logic [4:0] BLANK_TICKS = 5'h18;
   // Register map, byte addresses.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_INT_STAT = 4'h8;
   localparam logic [3:0] REG_INT_MASK = 4'hc;
   localparam int INT_W = 3;
   localparam int INT_FAULT = 0;
   localparam int INT_TRANS_DONE = 1;
   localparam int INT_RGOOD_UP = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_STEADY, ST_SYNC, ST_SLEW, ST_BLANK} slew_state_e;

   // Comparator and sensor flags from the analog front end.
   typedef struct packed {
      logic ov_dac_rel;
      logic ov_fixed;
      logic undervoltage;
      logic thermal_hot;
      logic thermal_cooled;
   } fault_flags_s;
endpackage

// ---- verification/vid_proc_model.sv ----
`timescale 1ns/1ps
module vid_proc_model (
   // Clock
   input wire logic sys_clk,
   // Bench requests
   input wire logic [4:0] code_req,
   input wire logic test_req,
   // Regulator pins
   output logic [4:0] vid_code_bits,
   output logic test_level_detect
);
   // All bits move on one edge, so no skewed code is ever seen.
   always @(posedge sys_clk) vid_code_bits <= code_req;
   always @(posedge sys_clk) test_level_detect <= test_req;
endmodule // vid_proc_model

// ---- verification/vid_slew_fault_sequencer_asserts.sv ----
`timescale 1ns/1ps
module vid_slew_fault_sequencer_asserts (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Watched inputs
   input wire logic overvoltage_protect_select,
   input wire logic skip_forced_pwm,
   input wire logic test_level_detect,
   input wire logic shutdown_n_input,
   input wire logic supply_below_1v,
   input wire vid_slew_pkg::fault_flags_s fault_flags,
   // Watched outputs
   input wire logic [vid_slew_pkg::DAC_W-1:0] dac_target,
   input wire logic low_side_gate_drive,
   input wire logic high_side_gate_drive,
   input wire logic overlap_mode_en,
   input wire logic fault_latched
);
   import vid_slew_pkg::*;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   property p_ov_fpwm;
      overvoltage_protect_select && skip_forced_pwm && fault_flags.ov_dac_rel
         && !test_level_detect |=> fault_latched;
   endproperty
   a_ov_fpwm: assert property (p_ov_fpwm) else $error("ov not latched");
   property p_ov_skip;
      overvoltage_protect_select && !skip_forced_pwm && fault_flags.ov_fixed
         && !test_level_detect |=> fault_latched;
   endproperty
   a_ov_skip: assert property (p_ov_skip) else $error("fixed ov not latched");
   property p_hot;
      fault_flags.thermal_hot && !test_level_detect |=> fault_latched;
   endproperty
   a_hot: assert property (p_hot) else $error("hot not latched");
   property p_hold;
      fault_latched && shutdown_n_input && !supply_below_1v && !test_level_detect
         |=> fault_latched;
   endproperty
   a_hold: assert property (p_hold) else $error("fault dropped");
   // Three cycles allow the rising test level to be seen before the clear lands.
   property p_test;
      test_level_detect [*3] |-> !fault_latched;
   endproperty
   a_test: assert property (p_test) else $error("test mode kept fault");
   property p_overlap;
      overlap_mode_en != test_level_detect;
   endproperty
   a_overlap: assert property (p_overlap) else $error("overlap wrong");
   property p_step;
      $changed(dac_target) |-> 6'(dac_target - $past(dac_target)) inside {6'h01, 6'h3f};
   endproperty
   a_step: assert property (p_step) else $error("dac jumped");
   property p_forced;
      fault_latched && dac_target == DAC_ZERO |-> low_side_gate_drive && !high_side_gate_drive;
   endproperty
   a_forced: assert property (p_forced) else $error("gates not forced");
   property p_no_rise;
      fault_latched |=> dac_target <= $past(dac_target);
   endproperty
   a_no_rise: assert property (p_no_rise) else $error("dac rose in fault");
   c_fault: cover property ($rose(fault_latched));
   c_top: cover property (dac_target == DAC_TOP_STEP);
   c_forced: cover property (fault_latched && low_side_gate_drive);
endmodule // vid_slew_fault_sequencer_asserts

bind vid_slew_fault_sequencer vid_slew_fault_sequencer_asserts u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n),
   .overvoltage_protect_select(overvoltage_protect_select),
   .skip_forced_pwm(skip_forced_pwm), .test_level_detect(test_level_detect),
   .shutdown_n_input(shutdown_n_input), .supply_below_1v(supply_below_1v),
   .fault_flags(fault_flags), .dac_target(dac_target),
   .low_side_gate_drive(low_side_gate_drive), .high_side_gate_drive(high_side_gate_drive),
   .overlap_mode_en(overlap_mode_en), .fault_latched(fault_latched));

// ---- verification/vid_slew_fault_sequencer_tb.sv ----
`timescale 1ns/1ps
module vid_slew_fault_sequencer_tb;
   import vid_slew_pkg::*;
   logic sys_clk = 1'h0, rst_n = 1'h0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rv;
   logic [4:0] code_req = 5'h00;
   logic [4:0] vid;
   logic test_req = 1'h0, test_lvl;
   logic shutdown_n_input_n = 1'h1, ovp_sel = 1'h1, skip = 1'h1, sup_low = 1'h0, pwm = 1'h0;
   fault_flags_s flags = '0;
   logic [DAC_W-1:0] dac;
   logic lsg, hsg, rgood, ovl, flt, irq;
   int seed = 76, error_cnt = 0, compares = 0, tn = 0;
   // Reference target in steps, kept from the decode rule rather than read back.
   int exp_dac = TOP_MV / LSB_MV;

   always #5 sys_clk = ~sys_clk;
   // Random on-time requests prove forced gates ignore the PWM path.
   always @(posedge sys_clk) pwm <= 1'($random(seed));

   vid_proc_model u_proc (.sys_clk(sys_clk), .code_req(code_req), .test_req(test_req),
      .vid_code_bits(vid), .test_level_detect(test_lvl));
   vid_slew_fault_sequencer #(.SLEW_DIV_DEFAULT(16'h0004)) u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .vid_code_bits(vid), .shutdown_n_input(shutdown_n_input_n), .test_level_detect(test_lvl),
      .overvoltage_protect_select(ovp_sel), .skip_forced_pwm(skip),
      .supply_below_1v(sup_low), .fault_flags(flags), .pwm_on_request(pwm),
      .dac_target(dac), .low_side_gate_drive(lsg), .high_side_gate_drive(hsg),
      .regulator_good_out(rgood), .overlap_mode_en(ovl), .fault_latched(flt), .irq(irq));

   task summarize;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task done_t;
      tn++;
      $display("test %0d done", tn);
   endtask

   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1);
      rs = bresp;
      bready <= 1'h0;
   endtask

   task rd(input logic [3:0] a);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         if (arready)
            arvalid <= 1'h0;
      end
      while (rvalid !== 1'h1);
      rv = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask

   task settle;
      int k;
      k = 0;
      do
      begin
         rd(REG_STATUS);
         k++;
      end
      while (rv[13:12] !== 2'h0 && k < 300);
   endtask

   task pulse(input fault_flags_s f);
      @(posedge sys_clk);
      flags <= f;
      @(posedge sys_clk);
      flags <= '0;
      repeat (2) @(posedge sys_clk);
   endtask

   task clr;
      @(posedge sys_clk);
      sup_low <= 1'h1;
      @(posedge sys_clk);
      sup_low <= 1'h0;
      @(posedge sys_clk);
   endtask

   // Undervoltage is held high across the slew to show it is blanked.
   task go(input int c);
      int e, d0, n, t;
      e = (c == 31) ? 0 : 62 - c;
      d0 = exp_dac;
      n = e > d0 ? e - d0 : d0 - e;
      t = 0;
      @(posedge sys_clk);
      code_req <= 5'(c);
      while (dac !== 6'(e) && t < 600)
      begin
         @(posedge sys_clk);
         t++;
         if (dac !== 6'(d0))
            flags.undervoltage <= 1'h1;
      end
      @(posedge sys_clk);
      flags.undervoltage <= 1'h0;
      chk(32'(dac), 32'(e));
      if (n > 0)
         chk(32'(e < d0 ? t >= 2*n+5 && t <= 2*n+9 : t >= 2*n-1 && t <= 2*n+4), 32'h1);
      settle();
      chk(32'(flt), 32'h0);
      chk(32'(rgood), 32'(e != 0));
      chk(32'(rv[5:0]), 32'(e));
      exp_dac = e;
   endtask

   initial
   begin
      repeat (60000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end

   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'h1;
      rd(REG_CTRL);
      chk(rv, 32'h4);
      rd(REG_INT_MASK);
      chk(rv, 32'h0);
      wr(REG_CTRL, 32'h2);
      wr(4'h1, 32'h1);
      chk(32'(rs), 32'(RESP_SLVERR));
      rd(4'h2);
      chk(32'(rs), 32'(RESP_SLVERR));
      chk(rv, 32'h0);
      rd(REG_CTRL);
      chk(rv, 32'h2);
      done_t();
      settle();
      chk(32'(dac), 32'(exp_dac));
      rd(REG_INT_STAT);
      chk(rv, 32'h6);
      for (int i = 0; i < 38; i++)
         go(i < 32 ? i : $random(seed) & 31);
      done_t();
      go(10);
      wr(REG_INT_MASK, 32'h1);
      pulse(5'h02);
      chk(32'(flt), 32'h1);
      chk(32'(irq), 32'h1);
      @(posedge sys_clk);
      code_req <= 5'h05;
      for (int k = 0; k < 400 && dac !== 6'h00; k++)
         @(posedge sys_clk);
      repeat (30) @(posedge sys_clk);
      chk(32'(dac), 32'h0);
      chk(32'({lsg, hsg}), 32'h2);
      rd(REG_STATUS);
      chk(32'(rv[10:9]), 32'h3);
      @(posedge sys_clk);
      shutdown_n_input_n <= 1'h0;
      repeat (3) @(posedge sys_clk);
      chk(32'(flt), 32'h1);
      flags.thermal_cooled <= 1'h1;
      repeat (3) @(posedge sys_clk);
      chk(32'(flt), 32'h0);
      shutdown_n_input_n <= 1'h1;
      flags.thermal_cooled <= 1'h0;
      wr(REG_INT_STAT, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(32'(irq), 32'h0);
      done_t();
      for (int i = 0; i < 4; i++)
      begin
         @(posedge sys_clk);
         ovp_sel <= i != 2;
         skip <= i != 1;
         pulse(i[0] ? 5'h08 : 5'h10);
         chk(32'(flt), 32'(i < 2));
         clr();
         chk(32'(flt), 32'h0);
      end
      done_t();
      pulse(5'h10);
      chk(32'(ovl), 32'h1);
      @(posedge sys_clk);
      test_req <= 1'h1;
      repeat (4) @(posedge sys_clk);
      chk(32'(flt), 32'h0);
      chk(32'(ovl), 32'h0);
      pulse(5'h1e);
      chk(32'(flt), 32'h0);
      test_req <= 1'h0;
      done_t();
      settle();
      pulse(5'h04);
      chk(32'(flt), 32'h1);
      clr();
      done_t();
      summarize();
   end
endmodule // vid_slew_fault_sequencer_tb
